// *** core/sss_map.vh ***
`ifndef SSS_MAP_VH
`define SSS_MAP_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define SSS_OFF_ZERO_THR    8'h00
`define SSS_OFF_ARR_THR     8'h04
`define SSS_OFF_UV_SEL      8'h08
`define SSS_OFF_PWR_OFF_T   8'h0C
`define SSS_OFF_STATUS      8'h10
`define SSS_OFF_IRQ_STAT    8'h14
`define SSS_OFF_IRQ_MASK    8'h18
`define SSS_OFF_CTRL        8'h1C
// ****************************************************************
// reset values and limits
// ****************************************************************
`define SSS_THR_RST         15'h0032
`define SSS_THR_MIN         15'h000A
`define SSS_THR_MAX         15'h4E20
`define SSS_HYST            15'h000A
`define SSS_UV_SEL_RST      1'h1
`define SSS_PWR_OFF_RST     10'h046
`define SSS_PWR_OFF_NOTRIP  10'h3E8
`define SSS_EV_RST          5'h03
// ****************************************************************
// timing: detection time unit is 1 ms
// ****************************************************************
`define SSS_CLK_HZ          25000000
`define SSS_UNIT_US         1000
`define SSS_UNIT_CYC        ((`SSS_CLK_HZ / 1000000) * `SSS_UNIT_US)
`define SSS_UNIT_LAST       15'h61A7
// ****************************************************************
// status and interrupt bit positions
// ****************************************************************
`define SSS_B_ZERO          0
`define SSS_B_VMATCH        1
`define SSS_B_ATSPD         2
`define SSS_B_SRVON         3
`define SSS_B_UVTRIP        4
`define SSS_B_MAINOFF       5
`define SSS_IRQ_W           5
`endif

// *** core/sss_cmp.v ***
`timescale 1ns/1ps
// ****************************************************************
// speed magnitude comparator with hysteresis
// ****************************************************************
module sss_cmp (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        sample,
    input  wire [14:0] mag,
    input  wire [14:0] thr,
    input  wire        above,
    output reg         flag_q
);
`include "sss_map.vh"
    wire [15:0] thr_hi;
    wire [15:0] thr_lo;
    assign thr_hi = {1'b0, thr} + {1'b0, `SSS_HYST};
    assign thr_lo = (thr > `SSS_HYST) ? {1'b0, thr - `SSS_HYST} : 16'h0000;
    // update once per sample; above=1 sets when magnitude exceeds thr
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= ~above;
        end else if (sample) begin
            if (above) begin
                if ({1'b0, mag} > {1'b0, thr})
                    flag_q <= 1'b1;
                else if ({1'b0, mag} <= thr_lo)
                    flag_q <= 1'b0;
            end else begin
                if (mag < thr)
                    flag_q <= 1'b1;
                else if ({1'b0, mag} >= thr_hi)
                    flag_q <= 1'b0;
            end
        end
    end
endmodule // sss_cmp

// *** core/sss_top.v ***
`timescale 1ns/1ps
// Function
// - zero-speed flag high while speed magnitude below zero-speed threshold.
// - speed-match flag high while command-speed difference below that threshold.
// - zero-speed compare uses magnitude, same for both directions.
// - zero-speed flag has 10 r/min hysteresis, clears at threshold plus 10.
// - at-speed flag high while speed exceeds arrival threshold, default 50.
// - arrival compare on magnitude with 10 r/min hysteresis.
// - trip decision only after main power off for detection time.
// - select 0: servo-off on loss, automatic servo-on on return.
// - select 1 (default): undervoltage trip on main power loss.
// - trip selection ignored when detection time equals 1000.
// - bus undervoltage trips at once regardless of selection.
module sss_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        speed_sample,
    input  wire [15:0] motor_speed,
    input  wire [15:0] command_speed,
    input  wire        main_power_ok,
    input  wire        bus_uv,
    input  wire        servo_on_req,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        zero_speed_flag,
    output wire        speed_match_flag,
    output wire        at_speed_flag,
    output reg         servo_enabled_q,
    output reg         undervoltage_trip,
    output wire        irq
);
`include "sss_map.vh"
    // ****************************************************************
    // registers
    // ****************************************************************
    reg [14:0] zero_speed_threshold;
    reg [14:0] arrival_speed_threshold;
    reg        uv_trip_select;
    reg [9:0]  power_off_detect_time;
    reg [`SSS_IRQ_W-1:0] irq_stat_q;
    reg [`SSS_IRQ_W-1:0] irq_mask_q;
    reg        trip_clr_q;
    // write channel capture, address and data in either order
    reg        aw_q;
    reg        w_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    // ****************************************************************
    // speed magnitudes
    // ****************************************************************
    wire [15:0] spd_abs;
    wire [16:0] diff;
    wire [16:0] diff_abs;
    wire [14:0] spd_mag;
    wire [14:0] diff_mag;
    // two's complement speeds; magnitude makes both directions alike
    assign spd_abs  = motor_speed[15] ? (~motor_speed + 16'h0001) : motor_speed;
    assign diff     = {command_speed[15], command_speed}
                    - {motor_speed[15], motor_speed};
    assign diff_abs = diff[16] ? (~diff + 17'h00001) : diff;
    // saturate to the 15-bit compare range
    assign spd_mag  = spd_abs[15] ? 15'h7FFF : spd_abs[14:0];
    assign diff_mag = (|diff_abs[16:15]) ? 15'h7FFF : diff_abs[14:0];
    // ****************************************************************
    // speed status comparators, one shared sample strobe
    // ****************************************************************
    sss_cmp u_zero (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sample  (speed_sample),
        .mag     (spd_mag),
        .thr     (zero_speed_threshold),
        .above   (1'b0),
        .flag_q  (zero_speed_flag)
    );
    sss_cmp u_vmatch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sample  (speed_sample),
        .mag     (diff_mag),
        .thr     (zero_speed_threshold),
        .above   (1'b0),
        .flag_q  (speed_match_flag)
    );
    sss_cmp u_atspd (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sample  (speed_sample),
        .mag     (spd_mag),
        .thr     (arrival_speed_threshold),
        .above   (1'b1),
        .flag_q  (at_speed_flag)
    );
    // ****************************************************************
    // main power loss timing
    // ****************************************************************
    reg [14:0] unit_cnt_q;
    reg [9:0]  off_ms_q;
    reg        off_det_q;
    wire       trip_sel_eff;
    wire       uv_event;
    wire       off_event;
    // detection time of 1000 leaves only the servo-off action
    assign trip_sel_eff = (power_off_detect_time == `SSS_PWR_OFF_NOTRIP)
                        ? 1'b0 : uv_trip_select;
    // loss is acted on once, when the ms count reaches the set time
    assign off_event = ~main_power_ok & ~off_det_q
                     & (off_ms_q >= power_off_detect_time);
    // faults count only while servo is on; bus sag skips the wait
    assign uv_event  = servo_enabled_q & ~undervoltage_trip
                     & (bus_uv | (off_event & trip_sel_eff));
    // count loss time in 1 ms units while power is off
    always @(posedge aclk) begin
        if (!aresetn || main_power_ok) begin
            unit_cnt_q <= 15'h0000;
            off_ms_q   <= 10'h000;
            off_det_q  <= 1'b0;
        end else begin
            // remember the detection until main power returns
            if (off_event)
                off_det_q <= 1'b1;
            // 1 ms prescaler; the ms count saturates instead of wrapping
            if (unit_cnt_q == `SSS_UNIT_LAST) begin
                unit_cnt_q <= 15'h0000;
                if (off_ms_q != 10'h3FF)
                    off_ms_q <= off_ms_q + 10'h001;
            end else begin
                unit_cnt_q <= unit_cnt_q + 15'h0001;
            end
        end
    end
    // servo enable and trip latch
    always @(posedge aclk) begin
        if (!aresetn) begin
            servo_enabled_q   <= 1'b0;
            undervoltage_trip <= 1'b0;
        end else begin
            // a new fault wins over a clear in the same cycle
            if (uv_event)
                undervoltage_trip <= 1'b1;
            else if (trip_clr_q)
                undervoltage_trip <= 1'b0;
            // servo drops on fault, dropped request or detected loss
            if (undervoltage_trip || uv_event || !servo_on_req)
                servo_enabled_q <= 1'b0;
            else if (off_det_q || off_event)
                servo_enabled_q <= 1'b0;
            else if (main_power_ok)
                servo_enabled_q <= 1'b1;
        end
    end
    // ****************************************************************
    // interrupt status: edges of flags, servo state, trip
    // ****************************************************************
    reg  [`SSS_IRQ_W-1:0] ev_prev_q;
    wire [`SSS_IRQ_W-1:0] ev_now;
    wire [`SSS_IRQ_W-1:0] ev_rise;
    wire                  wr_go;
    assign ev_now  = {undervoltage_trip, servo_enabled_q, at_speed_flag,
                      speed_match_flag, zero_speed_flag};
    // any change of a flag, servo state or trip is an event
    assign ev_rise = ev_now ^ ev_prev_q;
    // level interrupt while an unmasked sticky bit is set
    assign irq     = |(irq_stat_q & irq_mask_q);
    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    // no new beat is taken while a response waits
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;
    assign wr_go         = aw_q & w_q & ~s_axi_bvalid;
    // capture address and data in either order, then commit
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            zero_speed_threshold    <= `SSS_THR_RST;
            arrival_speed_threshold <= `SSS_THR_RST;
            uv_trip_select          <= `SSS_UV_SEL_RST;
            power_off_detect_time   <= `SSS_PWR_OFF_RST;
            irq_mask_q <= {`SSS_IRQ_W{1'b0}};
            irq_stat_q <= {`SSS_IRQ_W{1'b0}};
            // matches the flag reset values, so no false event after reset
            ev_prev_q  <= `SSS_EV_RST;
            trip_clr_q <= 1'b0;
        end else begin
            ev_prev_q  <= ev_now;
            trip_clr_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // set wins over write-one-to-clear
            irq_stat_q <= irq_stat_q | ev_rise;
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // out-of-range values are dropped, the response stays okay
                case (awaddr_q)
                    `SSS_OFF_ZERO_THR: begin
                        if (wstrb_q[0] && wstrb_q[1] &&
                            wdata_q[14:0] >= `SSS_THR_MIN &&
                            wdata_q[14:0] <= `SSS_THR_MAX)
                            zero_speed_threshold <= wdata_q[14:0];
                    end
                    `SSS_OFF_ARR_THR: begin
                        if (wstrb_q[0] && wstrb_q[1] &&
                            wdata_q[14:0] >= `SSS_THR_MIN &&
                            wdata_q[14:0] <= `SSS_THR_MAX)
                            arrival_speed_threshold <= wdata_q[14:0];
                    end
                    `SSS_OFF_UV_SEL: begin
                        if (wstrb_q[0])
                            uv_trip_select <= wdata_q[0];
                    end
                    `SSS_OFF_PWR_OFF_T: begin
                        if (wstrb_q[0] && wstrb_q[1] &&
                            wdata_q[9:0] <= `SSS_PWR_OFF_NOTRIP)
                            power_off_detect_time <= wdata_q[9:0];
                    end
                    `SSS_OFF_IRQ_STAT: begin
                        if (wstrb_q[0])
                            irq_stat_q <= (irq_stat_q
                                & ~wdata_q[`SSS_IRQ_W-1:0]) | ev_rise;
                    end
                    `SSS_OFF_IRQ_MASK: begin
                        if (wstrb_q[0])
                            irq_mask_q <= wdata_q[`SSS_IRQ_W-1:0];
                    end
                    `SSS_OFF_CTRL: begin
                        if (wstrb_q[0])
                            trip_clr_q <= wdata_q[0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    reg [31:0] rd_d;
    // one read at a time, next address taken after rready
    assign s_axi_arready = ~s_axi_rvalid;
    // read mux
    always @* begin
        rd_d = 32'h00000000;
        case (s_axi_araddr)
            `SSS_OFF_ZERO_THR:  rd_d[14:0] = zero_speed_threshold;
            `SSS_OFF_ARR_THR:   rd_d[14:0] = arrival_speed_threshold;
            `SSS_OFF_UV_SEL:    rd_d[0]    = uv_trip_select;
            `SSS_OFF_PWR_OFF_T: rd_d[9:0]  = power_off_detect_time;
            `SSS_OFF_STATUS:    rd_d[5:0]  = {~main_power_ok, ev_now};
            `SSS_OFF_IRQ_STAT:  rd_d[`SSS_IRQ_W-1:0] = irq_stat_q;
            `SSS_OFF_IRQ_MASK:  rd_d[`SSS_IRQ_W-1:0] = irq_mask_q;
            default:            rd_d = 32'h00000000;
        endcase
    end
    // one-cycle read answer, slverr on unmapped address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= (s_axi_araddr > `SSS_OFF_CTRL ||
                             s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // sss_top

// *** dv/sss_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// host controller model
// ****************************************
module sss_host_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       want_on,
    input  wire       undervoltage_trip,
    output reg        servo_on_req,
    output reg  [7:0] trip_cnt_q
);
    reg trip_q;

    // servo-on request follows the bench, each new fault is counted
    always @(posedge aclk) begin
        if (!aresetn) begin
            servo_on_req <= 1'b0;
            trip_q       <= 1'b0;
            trip_cnt_q   <= 8'h00;
        end else begin
            servo_on_req <= want_on;
            trip_q       <= undervoltage_trip;
            if (undervoltage_trip && !trip_q) begin
                trip_cnt_q <= trip_cnt_q + 8'h01;
            end
        end
    end
endmodule // sss_host_model

// *** dv/sss_top_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module sss_top_assertions (
    input wire        aclk,
    input wire        aresetn,
    input wire        speed_sample,
    input wire [15:0] motor_speed,
    input wire [15:0] command_speed,
    input wire        main_power_ok,
    input wire        bus_uv,
    input wire        servo_on_req,
    input wire        s_axi_bvalid,
    input wire        zero_speed_flag,
    input wire        speed_match_flag,
    input wire        at_speed_flag,
    input wire        servo_enabled_q,
    input wire        undervoltage_trip
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // speed magnitude and command difference magnitude
    wire        [15:0] mag = motor_speed[15] ? -motor_speed : motor_speed;
    wire signed [16:0] dif = $signed(motor_speed) - $signed(command_speed);
    wire        [16:0] adif = dif[16] ? -dif : dif;

    property p_zero;
        speed_sample && mag < 16'd10 |=> zero_speed_flag;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero speed flag low below minimum threshold");
    property p_match;
        speed_sample && adif < 17'd10 |=> speed_match_flag;
    endproperty
    a_match: assert property (p_match)
        else $error("speed match flag low with tiny difference");
    property p_atspd;
        speed_sample && motor_speed == 16'h0000 |=> !at_speed_flag;
    endproperty
    a_atspd: assert property (p_atspd)
        else $error("at speed flag high at standstill");
    property p_hold;
        !speed_sample |=> $stable(zero_speed_flag) &&
            $stable(speed_match_flag) && $stable(at_speed_flag);
    endproperty
    a_hold: assert property (p_hold)
        else $error("speed flag changed without a sample");
    property p_busuv;
        bus_uv && servo_enabled_q |-> ##[1:3] undervoltage_trip;
    endproperty
    a_busuv: assert property (p_busuv)
        else $error("bus undervoltage did not trip");
    property p_cause;
        $rose(undervoltage_trip) |-> $past(bus_uv) || !$past(main_power_ok);
    endproperty
    a_cause: assert property (p_cause)
        else $error("trip without power loss or bus undervoltage");
    property p_srvon;
        $rose(servo_enabled_q) |-> $past(servo_on_req) && $past(main_power_ok);
    endproperty
    a_srvon: assert property (p_srvon)
        else $error("servo on without request or main power");
    property p_latch;
        $fell(undervoltage_trip) |->
            s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_latch: assert property (p_latch)
        else $error("trip cleared without a register write");
endmodule // sss_top_assertions

bind sss_top sss_top_assertions u_chk (.*);

// *** dv/test_servo_speed_status_and_uv_trip.sv ***
`timescale 1ns/1ps
`include "sss_map.vh"
// ****************************************
// bench top
// ****************************************
module test_servo_speed_status_and_uv_trip;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         speed_sample = 1'b0;
    reg  [15:0] motor_speed = 16'h0000;
    reg  [15:0] command_speed = 16'h0000;
    reg         main_power_ok = 1'b1;
    reg         bus_uv = 1'b0;
    reg         want_on = 1'b0;
    reg  [7:0]  awaddr = 8'h00;
    reg  [7:0]  araddr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  wstrb = 4'hF;
    reg         awvalid = 1'b0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    wire        servo_on_req, awready, wready, bvalid, arready, rvalid, irq;
    wire        zero, vm, ats, srv, trip;
    wire [1:0]  rresp, bresp;
    wire [31:0] rdata;
    wire [7:0]  trips;
    integer     err_count = 0;
    integer     checks = 0;

    sss_top DUT (
        .aclk(aclk), .aresetn(aresetn), .speed_sample(speed_sample),
        .motor_speed(motor_speed), .command_speed(command_speed),
        .main_power_ok(main_power_ok), .bus_uv(bus_uv),
        .servo_on_req(servo_on_req), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .zero_speed_flag(zero),
        .speed_match_flag(vm), .at_speed_flag(ats),
        .servo_enabled_q(srv), .undervoltage_trip(trip), .irq(irq));

    sss_host_model u_host (.aclk(aclk), .aresetn(aresetn), .want_on(want_on),
        .undervoltage_trip(trip), .servo_on_req(servo_on_req),
        .trip_cnt_q(trips));

    // clock and hang guard
    always #20 aclk = ~aclk;
    initial begin
        #3200000;
        err_count = err_count + 1;
        finish_test;
    end

    task finish_test;
        begin
            $display("checks %0d err_count %0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task wr(input [7:0] a, input [31:0] d);
        reg ta, tw, tb;
        integer n;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            tb = 1'b0;
            n = 0;
            while (!tb && n < 50) begin
                @(negedge aclk);
                ta = awvalid & awready;
                tw = wvalid & wready;
                tb = bvalid;
                if (tb) chk("bresp", 0, bresp);
                @(posedge aclk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                n = n + 1;
            end
            bready <= 1'b0;
            if (!tb) chk("bvalid", 1, 0);
        end
    endtask

    // read and compare data and response
    task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
        reg tv, ta;
        integer n;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            tv = 1'b0;
            n = 0;
            while (!tv && n < 50) begin
                @(negedge aclk);
                ta = arvalid & arready;
                tv = rvalid;
                if (tv) chk("rdata", e, rdata);
                if (tv) chk("rresp", er, rresp);
                @(posedge aclk);
                if (ta) arvalid <= 1'b0;
                n = n + 1;
            end
            rready <= 1'b0;
            if (!tv) chk("rvalid", 1, 0);
        end
    endtask

    // one speed sample, then the three flags as {at, match, zero}
    task spd(input [15:0] m, input [15:0] c, input [2:0] e);
        begin
            @(posedge aclk);
            motor_speed <= m;
            command_speed <= c;
            speed_sample <= 1'b1;
            @(posedge aclk);
            speed_sample <= 1'b0;
            @(negedge aclk);
            chk("flags", e, {ats, vm, zero});
        end
    endtask

    task settle(input integer n);
        begin
            repeat (n) @(posedge aclk);
            @(negedge aclk);
        end
    endtask

    task wsrv(input e);
        integer n;
        begin
            n = 0;
            while (srv !== e && n < 200) begin
                settle(1);
                n = n + 1;
            end
            chk("servo", e, srv);
        end
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`SSS_OFF_ZERO_THR, 32'h32, 2'h0);
        rchk(`SSS_OFF_ARR_THR, 32'h32, 2'h0);
        rchk(`SSS_OFF_UV_SEL, 32'h1, 2'h0);
        rchk(8'h20, 32'h0, 2'h2);
        wr(`SSS_OFF_ZERO_THR, 32'h64);
        wr(`SSS_OFF_ZERO_THR, 32'h9);
        wr(`SSS_OFF_ARR_THR, 32'h4E21);
        wstrb <= 4'h1;
        wr(`SSS_OFF_ZERO_THR, 32'h20);
        wstrb <= 4'hF;
        rchk(`SSS_OFF_ZERO_THR, 32'h64, 2'h0);
        rchk(`SSS_OFF_ARR_THR, 32'h32, 2'h0);
        wr(`SSS_OFF_ARR_THR, 32'h4E20);
        rchk(`SSS_OFF_ARR_THR, 32'h4E20, 2'h0);
        wr(`SSS_OFF_ARR_THR, 32'hC8);
        spd(16'hFF9D, 16'hFF9D, 3'h3);
        spd(16'h0069, 16'h0000, 3'h3);
        spd(16'hFF92, 16'h0000, 3'h0);
        spd(16'h00C9, 16'h0064, 3'h4);
        spd(16'hFF41, 16'hFF6A, 3'h6);
        spd(16'h00BE, 16'h00BE, 3'h2);
        spd(16'h0000, 16'h0000, 3'h3);
        @(posedge aclk);
        motor_speed <= 16'h01F4;
        settle(3);
        chk("hold", 3'h3, {ats, vm, zero});
        wr(`SSS_OFF_IRQ_MASK, 32'h0);
        rchk(`SSS_OFF_IRQ_STAT, 32'h7, 2'h0);
        wr(`SSS_OFF_IRQ_MASK, 32'h4);
        settle(1);
        chk("irq", 1, irq);
        wr(`SSS_OFF_IRQ_STAT, 32'h4);
        settle(1);
        chk("irq", 0, irq);
        rchk(`SSS_OFF_IRQ_STAT, 32'h3, 2'h0);
        want_on <= 1'b1;
        wsrv(1'b1);
        @(posedge aclk);
        bus_uv <= 1'b1;
        settle(3);
        chk("trip", 1, trip);
        @(posedge aclk);
        bus_uv <= 1'b0;
        wr(`SSS_OFF_CTRL, 32'h1);
        settle(2);
        chk("trip", 0, trip);
        wsrv(1'b1);
        wr(`SSS_OFF_PWR_OFF_T, 32'h1);
        main_power_ok <= 1'b0;
        settle(24000);
        chk("trip", 0, trip);
        settle(1100);
        chk("trip", 1, trip);
        @(posedge aclk);
        main_power_ok <= 1'b1;
        wr(`SSS_OFF_CTRL, 32'h1);
        wsrv(1'b1);
        wr(`SSS_OFF_UV_SEL, 32'h0);
        main_power_ok <= 1'b0;
        settle(25100);
        chk("trip", 0, trip);
        chk("servo", 0, srv);
        rchk(`SSS_OFF_STATUS, 32'h23, 2'h0);
        main_power_ok <= 1'b1;
        wsrv(1'b1);
        wr(`SSS_OFF_PWR_OFF_T, 32'h3E8);
        rchk(`SSS_OFF_PWR_OFF_T, 32'h3E8, 2'h0);
        wr(`SSS_OFF_UV_SEL, 32'h1);
        main_power_ok <= 1'b0;
        settle(2000);
        chk("trip", 0, trip);
        @(posedge aclk);
        bus_uv <= 1'b1;
        settle(3);
        chk("trip", 1, trip);
        chk("trips", 3, trips);
        finish_test;
    end
endmodule // test_servo_speed_status_and_uv_trip
